// ===== logic/dgd_gate_loop.sv
`timescale 1ns/100ps
module dgd_gate_loop
  import dgd_pkg::*;
(
  input  wire logic        aclk,           // system clock
  input  wire logic        aresetn,        // sync reset, low
  input  wire logic [31:0] s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [31:0] s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read valid
  input  wire logic        s_axi_rready,   // read ready
  input  wire logic        data_strobe_clock,   // half-rate strobe pin
  input  wire logic        gate_trigger_input,  // gate/trigger lane pin
  input  wire logic [15:0] sample_in,           // sample lanes
  output logic             transmit_gate,       // transmit enabled
  output logic             align_pulse,         // one-cycle align event
  output logic [7:0]       align_sel_first,     // align effect bits
  output logic [7:0]       align_sel_second,    // align effect bits
  output logic [2:0]       loop_range,          // delay loop range
  output logic [3:0]       loop_offset,         // strobe skew offset
  output logic [15:0]      chan_a_sample,       // channel a code
  output logic [15:0]      chan_b_sample,       // channel b code
  output dgd_cur_t         true_current_out,    // channel a currents
  output dgd_cur_t         complement_current_out, // channel b currents
  output logic             irq                  // level interrupt
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  dgd_lane_t lane_s1_r, lane_s2_r;
  logic      stb_s1_r, stb_s2_r, stb_s3_r;

  // two flops before any logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lane_s1_r <= '0;
      lane_s2_r <= '0;
      stb_s1_r  <= 1'b0;
      stb_s2_r  <= 1'b0;
      stb_s3_r  <= 1'b0;
    end else begin
      lane_s1_r <= '{gate: gate_trigger_input, data: sample_in};
      lane_s2_r <= lane_s1_r;
      stb_s1_r  <= data_strobe_clock;
      stb_s2_r  <= stb_s1_r;
      stb_s3_r  <= stb_s2_r;
    end
  end

  logic stb_edge;
  assign stb_edge = stb_s2_r ^ stb_s3_r;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]       cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
  logic [1:0]       soft_r, soft_nxt;
  logic [7:0]       gain_r, gain_nxt;
  logic [7:0]       dly_r, dly_nxt;
  logic             restart_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt, iclr;
  logic [IRQ_W-1:0] iset;

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_go;
  logic        lock_r;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // capture address and data in either order, then commit
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    cfg1_nxt    = cfg1_r;
    cfg2_nxt    = cfg2_r;
    soft_nxt    = soft_r;
    gain_nxt    = gain_r;
    dly_nxt     = dly_r;
    ien_nxt     = ien_r;
    restart_nxt = 1'b0;
    iclr        = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    wr_go = aw_hold_r && w_hold_r;
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = 2'b00;
      if (w_strb_r[0]) begin
        unique case (aw_addr_r)
          ADDR_ALIGN_CFG1:   cfg1_nxt = w_data_r[7:0];
          ADDR_ALIGN_CFG2:   cfg2_nxt = w_data_r[7:0];
          ADDR_SOFT_ALIGN:   soft_nxt = w_data_r[1:0];
          ADDR_GAIN_CFG:     gain_nxt = w_data_r[7:0];
          ADDR_LOOP_RESTART: restart_nxt = w_data_r[0];
          ADDR_DELAY_LOOP:   dly_nxt = {w_data_r[7:4], 1'b0, w_data_r[2:0]};
          ADDR_IRQ_ENABLE:   ien_nxt = w_data_r[IRQ_W-1:0];
          ADDR_IRQ_CLEAR:    iclr = w_data_r[IRQ_W-1:0];
          ADDR_FIRST_STATUS_REG, ADDR_IRQ_STATUS: bresp_nxt = 2'b00;
          default:           bresp_nxt = 2'b10;
        endcase
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // read path answers one cycle after address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'b00;
      rdata_nxt  = 32'h00000000;
      unique case (s_axi_araddr[7:0])
        ADDR_ALIGN_CFG1:   rdata_nxt[7:0] = cfg1_r;
        ADDR_ALIGN_CFG2:   rdata_nxt[7:0] = cfg2_r;
        ADDR_SOFT_ALIGN:   rdata_nxt[1:0] = soft_r;
        ADDR_GAIN_CFG:     rdata_nxt[7:0] = gain_r;
        ADDR_LOOP_RESTART: rdata_nxt = 32'h00000000;
        ADDR_DELAY_LOOP:   rdata_nxt[7:0] = dly_r;
        ADDR_FIRST_STATUS_REG:      rdata_nxt[0] = lock_r;
        ADDR_IRQ_STATUS:   rdata_nxt[IRQ_W-1:0] = ist_r;
        ADDR_IRQ_ENABLE:   rdata_nxt[IRQ_W-1:0] = ien_r;
        ADDR_IRQ_CLEAR:    rdata_nxt = 32'h00000000;
        default:           rresp_nxt = 2'b10;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // register bus state and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'b00;
      rdata_r   <= 32'h00000000;
      cfg1_r    <= ALIGN_CFG_RST;
      cfg2_r    <= ALIGN_CFG_RST;
      soft_r    <= 2'b00;
      gain_r    <= {GAIN_RST, GAIN_RST};
      dly_r     <= {OFFSET_RST, 1'b0, RANGE_RST};
      ien_r     <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      cfg1_r    <= cfg1_nxt;
      cfg2_r    <= cfg2_nxt;
      soft_r    <= soft_nxt;
      gain_r    <= gain_nxt;
      dly_r     <= dly_nxt;
      ien_r     <= ien_nxt;
    end
  end

  assign align_sel_first  = cfg1_r;
  assign align_sel_second = cfg2_r;
  assign loop_range       = dly_r[RANGE_LSB +: 3];
  assign loop_offset      = dly_r[OFFSET_LSB +: 4];

  // ****************************************************************
  // delay loop
  // ****************************************************************
  dgd_loop_t  loop_r, loop_nxt;
  logic [4:0] edges_r, edges_nxt;
  logic [8:0] gap_r, gap_nxt;
  logic       lock_nxt, stalled;
  logic [3:0] skew_r, skew_nxt;

  assign stalled = (gap_r >= 9'(STALL_CYC));

  // count stable edges; stall or restart drops lock
  always_comb begin
    loop_nxt  = loop_r;
    edges_nxt = edges_r;
    gap_nxt   = stb_edge ? 9'h000 : (stalled ? gap_r : gap_r + 9'h001);
    skew_nxt  = skew_r;
    lock_nxt  = lock_r;
    unique case (loop_r)
      LOOP_IDLE: begin
        lock_nxt = 1'b0;
      end
      LOOP_ACQ: begin
        lock_nxt = 1'b0;
        if (stalled) begin
          edges_nxt = 5'h00;
        end else if (stb_edge) begin
          edges_nxt = edges_r + 5'h01;
          skew_nxt  = loop_offset;
        end
        if (edges_r >= 5'(LOCK_EDGES)) begin
          loop_nxt = LOOP_LOCKED;
          lock_nxt = 1'b1;
        end
      end
      LOOP_LOCKED: begin
        if (stalled) begin
          loop_nxt  = LOOP_ACQ;
          edges_nxt = 5'h00;
          lock_nxt  = 1'b0;
        end
      end
    endcase
    if (restart_nxt) begin
      loop_nxt  = LOOP_ACQ;
      edges_nxt = 5'h00;
      lock_nxt  = 1'b0;
    end
  end

  // register loop state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_r  <= LOOP_IDLE;
      edges_r <= 5'h00;
      gap_r   <= 9'h000;
      lock_r  <= 1'b0;
      skew_r  <= 4'h0;
    end else begin
      loop_r  <= loop_nxt;
      edges_r <= edges_nxt;
      gap_r   <= gap_nxt;
      lock_r  <= lock_nxt;
      skew_r  <= skew_nxt;
    end
  end

  // ****************************************************************
  // input fifo and gate
  // ****************************************************************
  dgd_lane_t  fifo_mem [FIFO_DEPTH];
  logic [2:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic       phase_r, phase_nxt, gate_prev_r, gate_prev_nxt, soft_trig_prev_r;
  logic       align_r, align_nxt, tx_r, tx_nxt;
  logic [15:0] a_r, a_nxt, b_r, b_nxt;
  dgd_lane_t  head;
  logic       gate_eff, soft_trig;

  assign head      = fifo_mem[rptr_r];
  assign soft_trig = soft_r[SOFT_TRIG_BIT] && !soft_trig_prev_r;

  // pointers run regardless of gate; lane pairs alternate channel
  always_comb begin
    wptr_nxt      = stb_edge ? wptr_r + 3'h1 : wptr_r;
    rptr_nxt      = stb_edge ? wptr_r - 3'h3 : rptr_r;
    phase_nxt     = stb_edge ? !phase_r : phase_r;
    gate_prev_nxt = gate_prev_r;
    gate_eff      = soft_r[SOFT_SEL_BIT] ? 1'b1 : head.gate;
    align_nxt     = 1'b0;
    tx_nxt        = tx_r;
    a_nxt         = a_r;
    b_nxt         = b_r;
    if (soft_r[SOFT_SEL_BIT]) begin
      align_nxt = soft_trig;
    end
    if (stb_edge) begin
      gate_prev_nxt = head.gate;
      tx_nxt        = gate_eff;
      if (!soft_r[SOFT_SEL_BIT]) begin
        align_nxt = head.gate && !gate_prev_r;
      end
      if (!phase_r) begin
        a_nxt = gate_eff ? head.data : ZERO_SAMPLE;
      end else begin
        b_nxt = gate_eff ? head.data : ZERO_SAMPLE;
      end
    end
    if (!tx_r) begin
      a_nxt = ZERO_SAMPLE;
      b_nxt = ZERO_SAMPLE;
    end
  end

  // fifo writes: gate bit stored beside data; reset leaves gated-off entries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_mem <= '{default: '0};  // no unknown head, no false gate rise
    end else if (stb_edge) begin
      fifo_mem[wptr_r] <= lane_s2_r;
    end
  end

  // register pipeline state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r           <= 3'h0;
      rptr_r           <= 3'h0;
      phase_r          <= 1'b0;
      gate_prev_r      <= 1'b0;
      soft_trig_prev_r <= 1'b0;
      align_r          <= 1'b0;
      tx_r             <= 1'b0;
      a_r              <= ZERO_SAMPLE;
      b_r              <= ZERO_SAMPLE;
    end else begin
      wptr_r           <= wptr_nxt;
      rptr_r           <= rptr_nxt;
      phase_r          <= phase_nxt;
      gate_prev_r      <= gate_prev_nxt;
      soft_trig_prev_r <= soft_r[SOFT_TRIG_BIT];
      align_r          <= align_nxt;
      tx_r             <= tx_nxt;
      a_r              <= a_nxt;
      b_r              <= b_nxt;
    end
  end

  assign transmit_gate = tx_r;
  assign align_pulse   = align_r;
  assign chan_a_sample = a_r;
  assign chan_b_sample = b_r;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign iset = {loop_r == LOOP_LOCKED && loop_nxt != LOOP_LOCKED,
                 !lock_r && lock_nxt, align_r};

  // set wins over clear
  always_comb begin
    ist_nxt = (ist_r & ~iclr) | iset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= '0;
    end else begin
      ist_r <= ist_nxt;
    end
  end

  assign irq = |(ist_r & ien_r);

  // ****************************************************************
  // current mapping per channel
  // ****************************************************************
  dgd_current_map u_map_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (a_r),
    .gain    (gain_r[GAIN_A_LSB +: 4]),
    .cur     (true_current_out)
  );

  dgd_current_map u_map_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (b_r),
    .gain    (gain_r[GAIN_B_LSB +: 4]),
    .cur     (complement_current_out)
  );

endmodule // dgd_gate_loop

// ===== shared/dgd_pkg.sv
package dgd_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_ALIGN_CFG1   = 8'h00;
  localparam logic [7:0] ADDR_SOFT_ALIGN   = 8'h04;
  localparam logic [7:0] ADDR_ALIGN_CFG2   = 8'h08;
  localparam logic [7:0] ADDR_GAIN_CFG     = 8'h0c;
  localparam logic [7:0] ADDR_LOOP_RESTART = 8'h10;
  localparam logic [7:0] ADDR_DELAY_LOOP   = 8'h14;
  localparam logic [7:0] ADDR_FIRST_STATUS_REG      = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR    = 8'h24;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          SOFT_SEL_BIT     = 0;
  localparam int          SOFT_TRIG_BIT    = 1;
  localparam int          GAIN_A_LSB       = 0;
  localparam int          GAIN_B_LSB       = 4;
  localparam int          RANGE_LSB        = 0;
  localparam int          OFFSET_LSB       = 4;
  localparam logic [3:0]  GAIN_RST         = 4'hf;
  localparam logic [2:0]  RANGE_RST        = 3'h0;
  localparam logic [3:0]  OFFSET_RST       = 4'h0;
  localparam logic [7:0]  ALIGN_CFG_RST    = 8'h00;
  localparam logic [15:0] ZERO_SAMPLE      = 16'h8000;
  localparam logic [16:0] CODE_SPAN        = 17'h10000;

  // irq bits: 0 align event, 1 lock acquired, 2 lock lost
  localparam int IRQ_W = 3;

  // ****************************************************************
  // delay loop timing
  // ****************************************************************
  localparam int LOCK_EDGES     = 16;   // stable strobe edges to lock
  localparam int STALL_NS       = 400;  // longest gap between edges
  localparam int CLK_NS         = 10;
  localparam int STALL_CYC      = STALL_NS / CLK_NS;
  localparam int FIFO_DEPTH     = 8;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic        gate;
    logic [15:0] data;
  } dgd_lane_t;

  typedef struct packed {
    logic [20:0] full_scale;   // gain code + 1 in bias-current units
    logic [36:0] comp_cur;     // full_scale * code
    logic [36:0] true_cur;     // full_scale * (span - code)
  } dgd_cur_t;

  typedef enum logic [1:0] {LOOP_IDLE, LOOP_ACQ, LOOP_LOCKED} dgd_loop_t;

endpackage

// ===== logic/dgd_current_map.sv
`timescale 1ns/100ps
module dgd_current_map
  import dgd_pkg::*;
(
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // sync reset, low
  input  wire logic [15:0] code,     // offset-binary sample
  input  wire logic [3:0]  gain,     // coarse gain code
  output dgd_cur_t         cur       // registered currents
);

  dgd_cur_t cur_r;
  dgd_cur_t cur_nxt;
  logic [4:0] fs;

  // full scale is gain plus one bias units, split by code
  always_comb begin
    fs                 = {1'b0, gain} + 5'h01;
    cur_nxt.full_scale = {16'h0000, fs};
    cur_nxt.comp_cur   = 37'(fs) * 37'(code);
    cur_nxt.true_cur   = 37'(fs) * (37'(CODE_SPAN) - 37'(code));
  end

  // register the result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign cur = cur_r;

endmodule // dgd_current_map

// ===== bench/dgd_gate_loop_assertions.sv
`timescale 1ns/100ps
module dgd_gate_loop_assertions
  import dgd_pkg::*;
(
  input wire logic        aclk,                  // system clock
  input wire logic        aresetn,               // sync reset, low
  input wire logic        s_axi_bvalid,          // write response valid
  input wire logic        s_axi_bready,          // write response ready
  input wire logic        s_axi_arready,         // read address ready
  input wire logic        s_axi_rvalid,          // read valid
  input wire logic        s_axi_rready,          // read ready
  input wire logic [31:0] s_axi_rdata,           // read data
  input wire logic        transmit_gate,         // transmit enabled
  input wire logic        align_pulse,           // align event
  input wire logic [15:0] chan_a_sample,         // channel a code
  input wire logic [15:0] chan_b_sample,         // channel b code
  input wire dgd_cur_t    true_current_out,      // channel a currents
  input wire dgd_cur_t    complement_current_out // channel b currents
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // *****
  // port checks
  // *****
  chk_zero_chan_a: assert property (
    !transmit_gate && !$past(transmit_gate) |-> chan_a_sample == ZERO_SAMPLE)
    else $error("chan a not zero while gated");
  chk_zero_chan_b: assert property (
    !transmit_gate && !$past(transmit_gate) |-> chan_b_sample == ZERO_SAMPLE)
    else $error("chan b not zero while gated");
  chk_align_single: assert property (align_pulse |=> !align_pulse)
    else $error("align pulse longer than one cycle");
  chk_comp_code_a: assert property ($past(aresetn) |->
    true_current_out.comp_cur == 37'(true_current_out.full_scale) * 37'($past(chan_a_sample)))
    else $error("chan a complement current wrong");
  chk_comp_code_b: assert property ($past(aresetn) |->
    complement_current_out.comp_cur ==
    37'(complement_current_out.full_scale) * 37'($past(chan_b_sample)))
    else $error("chan b complement current wrong");
  chk_cur_split_a: assert property ($past(aresetn) |->
    true_current_out.comp_cur + true_current_out.true_cur ==
    37'(true_current_out.full_scale) * 37'(CODE_SPAN))
    else $error("chan a currents do not sum to full scale");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  cov_gated: cover property (!transmit_gate && $past(transmit_gate));
  cov_align: cover property (align_pulse);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // dgd_gate_loop_assertions

bind dgd_gate_loop dgd_gate_loop_assertions u_chk (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .transmit_gate, .align_pulse, .chan_a_sample,
  .chan_b_sample, .true_current_out, .complement_current_out
);

// ===== bench/dgd_serial_model.sv
`timescale 1ns/100ps
module dgd_serial_model
  import dgd_pkg::*;
(
  input  wire logic   run,                // frame request
  input  wire logic   gate_cmd,           // gate level to send
  output logic        data_strobe_clock,  // half-rate strobe
  output logic        gate_trigger_input, // gate lane
  output logic [15:0] sample_in,          // sample lanes
  output int unsigned edges               // strobe edges sent
);
  // *****
  // serializer
  // *****
  // strobe still between frames, lanes scrambled while released
  initial begin
    data_strobe_clock = 1'b0;
    gate_trigger_input = 1'b1;
    sample_in = 16'h0000;
    edges = 0;
    forever begin
      if (run) begin
        repeat (2) begin
          sample_in = {(edges[0] ? 4'h2 : 4'h1), edges[11:0]};
          gate_trigger_input = gate_cmd;
          #20;
          data_strobe_clock = ~data_strobe_clock;
          edges++;
          #60;
        end
      end else begin
        sample_in = ~sample_in;
        #40;
      end
    end
  end
endmodule // dgd_serial_model

// ===== bench/dgd_gate_loop_bench.sv
`timescale 1ns/100ps
module dgd_gate_loop_bench;
  import dgd_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, data_strobe_clock, gate_trigger_input, transmit_gate;
  logic        align_pulse, irq, run, gate_cmd;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, loop_offset, ga, gb, of;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] sample_in, chan_a_sample, chan_b_sample;
  logic [7:0]  align_sel_first, align_sel_second, c1, c2;
  logic [2:0]  loop_range, rg;
  dgd_cur_t    true_current_out, complement_current_out;
  int unsigned edges;
  int          n_errors, total_checks, k;
  int          n_align = 0;

  dgd_gate_loop u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .data_strobe_clock, .gate_trigger_input, .sample_in,
    .transmit_gate, .align_pulse, .align_sel_first, .align_sel_second, .loop_range,
    .loop_offset, .chan_a_sample, .chan_b_sample, .true_current_out,
    .complement_current_out, .irq
  );
  dgd_serial_model u_far (
    .run, .gate_cmd, .data_strobe_clock, .gate_trigger_input, .sample_in, .edges
  );

  // *****
  // clock, counters, tasks
  // *****
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // counts align events
  always @(posedge aclk) if (align_pulse === 1'b1) n_align <= n_align + 1;

  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [36:0] exp, input logic [36:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do tick(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do tick(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // runs the far side for at least n strobe edges
  task automatic frame(input int unsigned n);
    int          t;
    int unsigned e0;
    t = 0;
    e0 = edges;
    run <= 1'b1;
    do tick(t); while (edges < e0 + n);
    run <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  // *****
  // main sequence
  // *****
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    run = 1'b0;
    gate_cmd = 1'b1;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'ha5f0));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ADDR_GAIN_CFG);
    chk("gain_reset", 37'hff, rd[7:0]);
    chk("fs_reset", 37'h10, true_current_out.full_scale);
    for (int i = 0; i < 4; i++) begin
      ga = (i == 0) ? 4'h0 : 4'($urandom);
      gb = (i == 0) ? 4'hf : 4'($urandom);
      {rg, of, c1, c2} = 23'($urandom);
      wr(ADDR_GAIN_CFG, {24'h0, gb, ga});
      wr(ADDR_DELAY_LOOP, {24'h0, of, 1'b0, rg});
      wr(ADDR_ALIGN_CFG1, {24'h0, c1});
      wr(ADDR_ALIGN_CFG2, {24'h0, c2});
      repeat (3) @(posedge aclk);
      chk("fs_a", ga + 1, true_current_out.full_scale);
      chk("fs_b", gb + 1, complement_current_out.full_scale);
      chk("range", rg, loop_range);
      chk("offset", of, loop_offset);
      chk("sel_first", c1, align_sel_first);
      chk("sel_second", c2, align_sel_second);
    end
    rdr(8'h40);
    chk("unmapped_rd", 2'b10, rs);
    wr(8'h44, 32'h0);
    chk("unmapped_wr", 2'b10, rs);
    wr(ADDR_IRQ_ENABLE, 32'h2);
    wr(ADDR_LOOP_RESTART, 32'h1);
    frame(24);
    wr(ADDR_LOOP_RESTART, 32'h1);
    rdr(ADDR_FIRST_STATUS_REG);
    chk("lock_cleared", 1'b0, rd[0]);
    frame(24);
    chk("irq_lock", 1'b1, irq);
    rdr(ADDR_FIRST_STATUS_REG);
    chk("lock_set", 1'b1, rd[0]);
    wr(ADDR_IRQ_CLEAR, 32'h2);
    repeat (50) @(posedge aclk);
    chk("irq_masked", 1'b0, irq);
    rdr(ADDR_FIRST_STATUS_REG);
    chk("lock_lost", 1'b0, rd[0]);
    rdr(ADDR_IRQ_STATUS);
    chk("irq_bits", 2'b10, rd[2:1]);
    gate_cmd = 1'b0;
    frame(8);
    chk("tx_off", 1'b0, transmit_gate);
    chk("a_zero", ZERO_SAMPLE, chan_a_sample);
    chk("b_zero", ZERO_SAMPLE, chan_b_sample);
    k = n_align;
    gate_cmd = 1'b1;
    frame(8);
    chk("align_ext", k + 1, n_align);
    chk("tx_on", 1'b1, transmit_gate);
    chk("lane_a", 4'h1, chan_a_sample[15:12]);
    chk("lane_b", 4'h2, chan_b_sample[15:12]);
    k = n_align;
    wr(ADDR_SOFT_ALIGN, 32'h1);
    wr(ADDR_SOFT_ALIGN, 32'h3);
    repeat (3) @(posedge aclk);
    chk("align_soft", k + 1, n_align);
    complete_run();
  end
endmodule // dgd_gate_loop_bench
